// *** pfs_row_sequencer.sv ***
// Flash row erase and write sequencer with APB register file and unlock keys
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.svh"

module pfs_row_sequencer
  import pfs_pkg::*;
#(
  parameter int ERASE_CYCLES = `PFS_ERASE_CYCLES  // Row erase length in clocks
)(
  input  wire logic        core_clk,        // System clock, 10 MHz
  input  wire logic        reset,           // Async reset, active high
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB write
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error, unmapped address
  input  wire logic        flash_torn,      // Flash saw a write cut by reset
  output logic             flash_erase,     // Erase row pulse
  output logic             flash_prog,      // Program word pulse
  output logic             flash_region,    // 1: user ID area
  output logic      [14:0] flash_addr,      // Word address to flash
  output logic      [13:0] flash_wdata,     // Word to program
  output logic             cpu_stall,       // Holds CPU while busy
  output logic             nvm_irq          // Done interrupt request
);

  localparam int PROG_CYCLES = `PFS_PROG_CYCLES;

  // Register state
  logic [7:0]  nvm_addr_low_ff;
  logic [6:0]  nvm_addr_high_ff;
  logic [7:0]  nvm_data_low_ff;
  logic [5:0]  nvm_data_high_ff;
  logic [14:0] wp_limit_ff;
  logic        program_go_ff;
  logic        modify_allow_ff;
  logic        erase_select_ff;
  logic        latch_only_load_ff;
  logic        region_select_ff;
  logic        fault_flag_ff;
  logic        nvm_done_flag_ff;
  logic        nvm_done_irq_enable_ff;
  pfs_key_t    key_ff;
  pfs_seq_t    seq_ff;
  logic [15:0] cnt_ff;
  logic [4:0]  idx_ff;
  logic        torn_meta_ff;
  logic        torn_sync_ff;
  logic        torn_seen_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        flash_erase_ff;
  logic        flash_prog_ff;
  logic        flash_region_ff;
  logic [14:0] flash_addr_ff;
  logic [13:0] flash_wdata_ff;
  logic        cpu_stall_ff;
  logic        nvm_irq_ff;

  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_key;
  logic        busy;
  logic        go_req;
  logic        unlocked;
  logic        start_ok;
  logic        protected_addr;
  logic        start_erase;
  logic        start_prog;
  logic        latch_load;
  logic        prot_fault;
  logic        key_fault;
  logic        torn_rise;
  logic        op_end;
  logic [14:0] full_addr;
  logic [9:0]  row_addr;
  logic [13:0] latch_word;
  logic [31:0] nxt_prdata;

  // APB decode
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pready_ff && pwrite;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `PFS_OFS_STATUS);
  assign wr_ctrl = wr_acc && (paddr == `PFS_OFS_CTRL);
  assign wr_key  = wr_acc && (paddr == `PFS_OFS_KEY);
  assign busy    = (seq_ff != PFS_IDLE);

  // Address split: ten row bits above five latch bits
  assign full_addr = {nvm_addr_high_ff, nvm_addr_low_ff};
  assign row_addr  = full_addr[14:5];

  // Start decode from the very write that sets go, so its mode bits count
  assign go_req         = wr_ctrl && pwdata[`PFS_BIT_GO] && !busy;
  assign unlocked       = (key_ff == PFS_KEY_ARMED);
  assign start_ok       = go_req && unlocked && pwdata[`PFS_BIT_MODIFY];
  assign protected_addr = !pwdata[`PFS_BIT_REGION] && (full_addr < wp_limit_ff);
  assign start_erase    = start_ok && pwdata[`PFS_BIT_ERASE] && !protected_addr;
  assign latch_load     = start_ok && !pwdata[`PFS_BIT_ERASE] && pwdata[`PFS_BIT_LATCH];
  assign start_prog     = start_ok && !pwdata[`PFS_BIT_ERASE] && !pwdata[`PFS_BIT_LATCH]
                          && !protected_addr;
  // Latch loads ignore protection since no memory is touched
  assign prot_fault     = start_ok && !(pwdata[`PFS_BIT_LATCH] && !pwdata[`PFS_BIT_ERASE])
                          && protected_addr;
  // Any other write between the keys and go breaks the unlock
  assign key_fault      = wr_acc && (key_ff != PFS_KEY_IDLE) && !start_ok
                          && !(wr_key && (key_ff == PFS_KEY_GOT_FIRST)
                               && (pwdata[7:0] == `PFS_KEY_SECOND));
  assign op_end         = busy && (cnt_ff == 16'h0000)
                          && ((seq_ff == PFS_ERASE) || (idx_ff == 5'h1f));

  // Unlock key tracker
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      key_ff <= PFS_KEY_IDLE;
    end else if (wr_acc) begin
      unique case (key_ff)
        PFS_KEY_IDLE:      key_ff <= (wr_key && pwdata[7:0] == `PFS_KEY_FIRST) ? PFS_KEY_GOT_FIRST
                                                                              : PFS_KEY_IDLE;
        PFS_KEY_GOT_FIRST: key_ff <= (wr_key && pwdata[7:0] == `PFS_KEY_SECOND) ? PFS_KEY_ARMED
                                                                               : PFS_KEY_IDLE;
        PFS_KEY_ARMED:     key_ff <= PFS_KEY_IDLE;  // Keys are spent by the next write
      endcase
    end
  end

  // Address, data and protect limit; frozen while an operation runs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nvm_addr_low_ff  <= 8'h00;
      nvm_addr_high_ff <= 7'h00;
      nvm_data_low_ff  <= 8'h00;
      nvm_data_high_ff <= 6'h00;
      wp_limit_ff      <= `PFS_WP_LIMIT_RST;
    end else if (wr_acc && !busy) begin
      if (paddr == `PFS_OFS_ADDR_LOW)  nvm_addr_low_ff  <= pwdata[7:0];
      if (paddr == `PFS_OFS_ADDR_HIGH) nvm_addr_high_ff <= pwdata[6:0];
      if (paddr == `PFS_OFS_DATA_LOW)  nvm_data_low_ff  <= pwdata[7:0];
      if (paddr == `PFS_OFS_DATA_HIGH) nvm_data_high_ff <= pwdata[5:0];
      if (paddr == `PFS_OFS_WP_LIMIT)  wp_limit_ff      <= pwdata[14:0];
    end
  end

  // Mode bits; an erase or program never touches modify_allow
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      modify_allow_ff        <= 1'b0;
      erase_select_ff        <= 1'b0;
      latch_only_load_ff     <= 1'b0;
      region_select_ff       <= 1'b0;
      nvm_done_irq_enable_ff <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      modify_allow_ff        <= pwdata[`PFS_BIT_MODIFY];
      erase_select_ff        <= pwdata[`PFS_BIT_ERASE];
      latch_only_load_ff     <= pwdata[`PFS_BIT_LATCH];
      region_select_ff       <= pwdata[`PFS_BIT_REGION];
      nvm_done_irq_enable_ff <= pwdata[`PFS_BIT_IRQ_EN];
    end
  end

  // Go bit: set only by an accepted start, cleared by hardware at the end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      program_go_ff <= 1'b0;
    end else if (start_erase || start_prog) begin
      program_go_ff <= 1'b1;
    end else if (op_end) begin
      program_go_ff <= 1'b0;
    end
  end

  // Torn-write report from the flash, crossed in by two flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      torn_meta_ff <= 1'b0;
      torn_sync_ff <= 1'b0;
      torn_seen_ff <= 1'b0;
    end else begin
      torn_meta_ff <= flash_torn;
      torn_sync_ff <= torn_meta_ff;
      torn_seen_ff <= torn_sync_ff;
    end
  end
  assign torn_rise = torn_sync_ff && !torn_seen_ff;

  // Fault flag: software may write it, a hardware set wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fault_flag_ff <= 1'b0;
    end else if (prot_fault || key_fault || torn_rise) begin
      fault_flag_ff <= 1'b1;
    end else if (wr_ctrl) begin
      fault_flag_ff <= pwdata[`PFS_BIT_FAULT];
    end
  end

  // Done flag: set at the end of an erase or row program, set wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nvm_done_flag_ff <= 1'b0;
    end else if (op_end) begin
      nvm_done_flag_ff <= 1'b1;
    end else if (wr_ctrl) begin
      nvm_done_flag_ff <= pwdata[`PFS_BIT_DONE];
    end
  end

  // Interrupt follows the flag, gated by nvm_done_irq_enable_ff, one cycle later
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nvm_irq_ff <= 1'b0;
    end else begin
      nvm_irq_ff <= nvm_done_flag_ff && nvm_done_irq_enable_ff;
    end
  end

  // Operation sequencer: one erase wait, or 32 timed word programs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seq_ff <= PFS_IDLE;
      cnt_ff <= 16'h0000;
      idx_ff <= 5'h00;
    end else begin
      unique case (seq_ff)
        PFS_IDLE: begin
          idx_ff <= 5'h00;
          if (start_erase) begin
            seq_ff <= PFS_ERASE;
            cnt_ff <= 16'(ERASE_CYCLES - 1);
          end else if (start_prog) begin
            seq_ff <= PFS_PROG;
            cnt_ff <= 16'(PROG_CYCLES - 1);
          end
        end
        PFS_ERASE: begin
          if (cnt_ff == 16'h0000) begin
            seq_ff <= PFS_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        PFS_PROG: begin
          if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
          end else if (idx_ff == 5'h1f) begin
            seq_ff <= PFS_IDLE;
          end else begin
            idx_ff <= idx_ff + 5'h01;
            cnt_ff <= 16'(PROG_CYCLES - 1);
          end
        end
      endcase
    end
  end

  // Flash command outputs; each pulse starts one timed step
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flash_erase_ff  <= 1'b0;
      flash_prog_ff   <= 1'b0;
      flash_region_ff <= 1'b0;
      flash_addr_ff   <= 15'h0000;
      flash_wdata_ff  <= 14'h0000;
    end else begin
      flash_erase_ff <= start_erase;
      flash_prog_ff  <= start_prog || ((seq_ff == PFS_PROG) && (cnt_ff == 16'h0000) && (idx_ff != 5'h1f));
      if (start_erase || start_prog) begin
        flash_region_ff <= pwdata[`PFS_BIT_REGION];
        flash_addr_ff   <= {row_addr, 5'h00};
        flash_wdata_ff  <= start_prog ? latch_word : `PFS_BLANK_WORD;
      end else if ((seq_ff == PFS_PROG) && (cnt_ff == 16'h0000) && (idx_ff != 5'h1f)) begin
        flash_addr_ff  <= {row_addr, idx_ff + 5'h01};
        flash_wdata_ff <= latch_word;
      end
    end
  end

  // CPU held from the start of an erase or program until it ends
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cpu_stall_ff <= 1'b0;
    end else begin
      cpu_stall_ff <= start_erase || start_prog || (busy && !op_end);
    end
  end

  // Latch bank: idle reads the first word ahead of the start pulse
  pfs_write_latches u_latches (
    .core_clk  (core_clk),
    .reset     (reset),
    .load_en   (latch_load),
    .load_idx  (nvm_addr_low_ff[4:0]),
    .load_data ({nvm_data_high_ff, nvm_data_low_ff}),
    .blank_all (op_end && (seq_ff == PFS_PROG)),
    .rd_idx    ((seq_ff == PFS_PROG) ? idx_ff + 5'h01 : 5'h00),
    .rd_data   (latch_word)
  );

  // Read mux, sampled in the setup cycle so data is ready in the access phase
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      `PFS_OFS_CTRL: begin
        nxt_prdata[`PFS_BIT_GO]     = program_go_ff;
        nxt_prdata[`PFS_BIT_MODIFY] = modify_allow_ff;
        nxt_prdata[`PFS_BIT_ERASE]  = erase_select_ff;
        nxt_prdata[`PFS_BIT_LATCH]  = latch_only_load_ff;
        nxt_prdata[`PFS_BIT_REGION] = region_select_ff;
        nxt_prdata[`PFS_BIT_FAULT]  = fault_flag_ff;
        nxt_prdata[`PFS_BIT_DONE]   = nvm_done_flag_ff;
        nxt_prdata[`PFS_BIT_IRQ_EN] = nvm_done_irq_enable_ff;
      end
      `PFS_OFS_ADDR_LOW:  nxt_prdata[7:0]  = nvm_addr_low_ff;
      `PFS_OFS_ADDR_HIGH: nxt_prdata[6:0]  = nvm_addr_high_ff;
      `PFS_OFS_DATA_LOW:  nxt_prdata[7:0]  = nvm_data_low_ff;
      `PFS_OFS_DATA_HIGH: nxt_prdata[5:0]  = nvm_data_high_ff;
      `PFS_OFS_WP_LIMIT:  nxt_prdata[14:0] = wp_limit_ff;
      `PFS_OFS_STATUS:    nxt_prdata[4:0]  = {busy, key_ff, 1'b0, idx_ff == 5'h1f};  // Bit 1 spare, reads zero
      default:            nxt_prdata       = 32'h0000_0000;  // Key reads as zero
    endcase
  end

  // APB answer: one wait-free access phase after each setup
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign flash_erase  = flash_erase_ff;
  assign flash_prog   = flash_prog_ff;
  assign flash_region = flash_region_ff;
  assign flash_addr   = flash_addr_ff;
  assign flash_wdata  = flash_wdata_ff;
  assign cpu_stall    = cpu_stall_ff;
  assign nvm_irq      = nvm_irq_ff;

endmodule
`default_nettype wire

// *** pfs_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the flash row sequencer
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// Register byte offsets on APB
`define PFS_OFS_CTRL      8'h00
`define PFS_OFS_KEY       8'h04
`define PFS_OFS_ADDR_LOW  8'h08
`define PFS_OFS_ADDR_HIGH 8'h0c
`define PFS_OFS_DATA_LOW  8'h10
`define PFS_OFS_DATA_HIGH 8'h14
`define PFS_OFS_WP_LIMIT  8'h18
`define PFS_OFS_STATUS    8'h1c

// Control register field positions
`define PFS_BIT_GO        0
`define PFS_BIT_MODIFY    1
`define PFS_BIT_ERASE     2
`define PFS_BIT_LATCH     3
`define PFS_BIT_REGION    4
`define PFS_BIT_FAULT     5
`define PFS_BIT_DONE      6
`define PFS_BIT_IRQ_EN    7

// Unlock keys
`define PFS_KEY_FIRST     8'h55
`define PFS_KEY_SECOND    8'haa

// Geometry and blank value
`define PFS_LATCH_COUNT   32
`define PFS_BLANK_WORD    14'h3fff
`define PFS_WP_LIMIT_RST  15'h0000

// Timing: times in microseconds, clock in MHz
`define PFS_CLK_MHZ        10
`define PFS_ERASE_TIME_US  2000
`define PFS_PROG_TIME_US   50
`define PFS_ERASE_CYCLES   (`PFS_ERASE_TIME_US * `PFS_CLK_MHZ)
`define PFS_PROG_CYCLES    (`PFS_PROG_TIME_US * `PFS_CLK_MHZ)

`endif

// *** pfs_pkg.sv ***
// Types shared by the flash row sequencer
package pfs_pkg;
  // Operation sequencer states
  typedef enum logic [1:0] {
    PFS_IDLE,
    PFS_ERASE,
    PFS_PROG
  } pfs_seq_t;

  // Unlock key progress
  typedef enum logic [1:0] {
    PFS_KEY_IDLE,
    PFS_KEY_GOT_FIRST,
    PFS_KEY_ARMED
  } pfs_key_t;
endpackage

// *** pfs_write_latches.sv ***
// Bank of 32 row write latches, each blank after reset
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.svh"

module pfs_write_latches
  import pfs_pkg::*;
(
  input  wire logic        core_clk,   // System clock
  input  wire logic        reset,      // Async reset, active high
  input  wire logic        load_en,    // Load one latch
  input  wire logic [4:0]  load_idx,   // Latch to load
  input  wire logic [13:0] load_data,  // Word to load
  input  wire logic        blank_all,  // Return every latch to blank
  input  wire logic [4:0]  rd_idx,     // Latch to read
  output logic      [13:0] rd_data     // Word of the read latch
);

  logic [13:0] latch_ff [`PFS_LATCH_COUNT];

  // One register per latch; blanking wins because it ends a row program
  for (genvar i = 0; i < `PFS_LATCH_COUNT; i++) begin : g_latch
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        latch_ff[i] <= `PFS_BLANK_WORD;
      end else if (blank_all) begin
        latch_ff[i] <= `PFS_BLANK_WORD;
      end else if (load_en && (load_idx == 5'(i))) begin
        latch_ff[i] <= load_data;
      end
    end
  end

  assign rd_data = latch_ff[rd_idx];

endmodule
`default_nettype wire

// *** pfs_row_sequencer_props.sv ***
// Concurrent checks on the flash row sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pfs_row_sequencer_props #(
  parameter int ERASE_CYCLES = 20  // Row erase length in clocks
)(
  input wire logic        core_clk,     // System clock
  input wire logic        reset,        // Async reset
  input wire logic        psel,         // APB select
  input wire logic        penable,      // APB enable
  input wire logic        pready,       // APB ready
  input wire logic        pslverr,      // APB error
  input wire logic        flash_erase,  // Erase pulse
  input wire logic        flash_prog,   // Program pulse
  input wire logic [14:0] flash_addr,   // Flash word address
  input wire logic [13:0] flash_wdata,  // Flash word
  input wire logic        cpu_stall     // CPU hold
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic        erasing_ff;    // Current busy span is an erase
  logic [15:0] stall_cnt_ff;  // Busy cycles so far
  logic [5:0]  prog_cnt_ff;   // Program pulses in this span
  logic [9:0]  row_ff;        // Row of the first program pulse

  // Span bookkeeping; counts restart when busy drops so each span is judged alone
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      erasing_ff   <= 1'b0;
      stall_cnt_ff <= 16'h0000;
    end else begin
      erasing_ff   <= flash_erase | (erasing_ff & cpu_stall);
      stall_cnt_ff <= cpu_stall ? stall_cnt_ff + 16'h0001 : 16'h0000;
    end
  end

  // Pulse count and row capture for row programs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prog_cnt_ff <= 6'h00;
      row_ff      <= 10'h000;
    end else begin
      prog_cnt_ff <= !cpu_stall ? 6'h00 : prog_cnt_ff + {5'h00, flash_prog};
      if (flash_prog && prog_cnt_ff == 6'h00) row_ff <= flash_addr[14:5];
    end
  end

  property p_ready; psel && !penable |=> pready && psel && penable; endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_erase_stall; flash_erase |-> cpu_stall; endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("erase without stall");
  property p_erase_pulse; flash_erase |=> !flash_erase && cpu_stall; endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse shape");
  property p_erase_row; flash_erase |-> flash_addr[4:0] == 5'h00 && flash_wdata == 14'h3fff; endproperty
  a_erase_row: assert property (p_erase_row) else $error("erase not whole row");
  property p_stall_len;
    $fell(cpu_stall) && erasing_ff |-> stall_cnt_ff >= ERASE_CYCLES - 1 && stall_cnt_ff <= ERASE_CYCLES + 1;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("erase stall length");
  property p_prog_count; $fell(cpu_stall) && !erasing_ff |-> prog_cnt_ff == 6'd32; endproperty
  a_prog_count: assert property (p_prog_count) else $error("row program pulse count");
  property p_prog_addr;
    flash_prog |-> flash_addr[4:0] == prog_cnt_ff[4:0] && (prog_cnt_ff == 6'h00 || flash_addr[14:5] == row_ff);
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("program address order");
  property p_no_erase; cpu_stall && $past(cpu_stall) && !erasing_ff |-> !flash_erase; endproperty
  a_no_erase: assert property (p_no_erase) else $error("erase inside program");
  c_erase: cover property ($fell(cpu_stall) && erasing_ff);
  c_prog: cover property ($fell(cpu_stall) && !erasing_ff);
  c_err: cover property (pslverr);
endmodule
`default_nettype wire

// *** tb_pfs_row_sequencer.sv ***
// Self-checking bench for the flash row sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.svh"
module tb_pfs_row_sequencer;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} pfs_tb_row_t;
  localparam logic [31:0] k_go = 32'h1 << `PFS_BIT_GO;
  localparam logic [31:0] k_mod = 32'h1 << `PFS_BIT_MODIFY;
  localparam logic [31:0] k_er = 32'h1 << `PFS_BIT_ERASE;
  localparam logic [31:0] k_lt = 32'h1 << `PFS_BIT_LATCH;
  localparam logic [31:0] k_rg = 32'h1 << `PFS_BIT_REGION;
  localparam logic [31:0] k_ft = 32'h1 << `PFS_BIT_FAULT;
  localparam logic [31:0] k_dn = 32'h1 << `PFS_BIT_DONE;
  localparam logic [31:0] k_ie = 32'h1 << `PFS_BIT_IRQ_EN;
  logic        core_clk, reset, psel, penable, pwrite, flash_torn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ie, rg;
  logic        pready, pslverr, flash_erase, flash_prog, flash_region, cpu_stall, nvm_irq, rd_err;
  logic [14:0] flash_addr, er_addr;
  logic [13:0] flash_wdata, pm [32];
  logic [9:0]  p_row;
  logic        er_region;
  int          n_fail, n_tests, n_erase, n_prog, n, p;
  pfs_tb_row_t rows [6] = '{'{8'h08, 32'h0a5, 32'h0a5, 1'b0}, '{8'h0c, 32'hffffffff, 32'h07f, 1'b0},
    '{8'h10, 32'h05a, 32'h05a, 1'b0}, '{8'h14, 32'hffffffff, 32'h03f, 1'b0},
    '{8'h1c, 32'h0ff, 32'h000, 1'b0}, '{8'h20, 32'h001, 32'h000, 1'b1}};

  // Clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  pfs_row_sequencer #(.ERASE_CYCLES(20)) dut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_torn(flash_torn),
    .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_region(flash_region), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .cpu_stall(cpu_stall), .nvm_irq(nvm_irq));

  // Records what reaches the flash; pre-edge values are read so no race with the design
  always @(posedge core_clk) begin
    if (flash_erase === 1'b1) begin
      n_erase++;
      er_addr = flash_addr;
      er_region = flash_region;
    end
    if (flash_prog === 1'b1) begin
      n_prog++;
      pm[flash_addr[4:0]] = flash_wdata;
      p_row = flash_addr[14:5];
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(32'(pready), 32'h1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic unlock(input logic [31:0] c);
    apb(1'b1, `PFS_OFS_KEY, {24'h0, `PFS_KEY_FIRST});
    apb(1'b1, `PFS_OFS_KEY, {24'h0, `PFS_KEY_SECOND});
    apb(1'b1, `PFS_OFS_CTRL, c);
  endtask

  task automatic wait_idle();
    int k;
    repeat (2) @(posedge core_clk);
    k = 0;
    while (cpu_stall !== 1'b0 && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
    chk(32'(cpu_stall), 32'h0);
  endtask

  task automatic ld(input logic [7:0] lo, input logic [13:0] d);
    apb(1'b1, `PFS_OFS_ADDR_LOW, {24'h0, lo});
    apb(1'b1, `PFS_OFS_DATA_LOW, {24'h0, d[7:0]});
    apb(1'b1, `PFS_OFS_DATA_HIGH, {26'h0, d[13:8]});
    unlock(k_go | k_mod | k_lt);
  endtask

  task automatic complete_run();
    $display("tests %0d fail %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond two row programs
  initial begin
    #(80000 * 100);
    n_fail++;
    complete_run();
  end

  initial begin
    {reset, psel, penable, pwrite, flash_torn, paddr, pwdata, n_fail, n_tests, n_erase, n_prog} = '0;
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // Register table: reset value, write, error response, readback
    foreach (rows[i]) begin
      rdc(rows[i].a, 32'h0);
      apb(1'b1, rows[i].a, rows[i].d);
      chk(32'(rd_err), 32'(rows[i].e));
      rdc(rows[i].a, rows[i].q);
    end
    // Protected erase refused and flagged
    apb(1'b1, `PFS_OFS_WP_LIMIT, 32'h7fff);
    apb(1'b1, `PFS_OFS_ADDR_HIGH, 32'h01);
    apb(1'b1, `PFS_OFS_ADDR_LOW, 32'h23);
    n = n_erase;
    unlock(k_go | k_mod | k_er);
    rdc(`PFS_OFS_CTRL, k_mod | k_er | k_ft);
    chk(n_erase, n);
    apb(1'b1, `PFS_OFS_WP_LIMIT, 32'h0);
    // Row erase in both regions, interrupt enabled then masked
    for (int r = 0; r < 2; r++) begin
      rg = r ? k_rg : 32'h0;
      ie = r ? 32'h0 : k_ie;
      n = n_erase;
      apb(1'b1, `PFS_OFS_CTRL, k_mod | k_er | ie | rg);
      unlock(k_go | k_mod | k_er | ie | rg);
      wait_idle();
      chk(n_erase, n + 1);
      chk(32'(er_addr), 32'h0120);
      chk(32'(er_region), r);
      rdc(`PFS_OFS_CTRL, k_mod | k_er | ie | rg | k_dn);
      chk(32'(nvm_irq), !r);
      apb(1'b1, `PFS_OFS_CTRL, k_mod | k_er | ie | rg);
      repeat (2) @(posedge core_clk);
      chk(32'(nvm_irq), 0);
    end
    // Broken unlock: fault, then no erase
    n = n_erase;
    apb(1'b1, `PFS_OFS_KEY, 32'h55);
    apb(1'b1, `PFS_OFS_ADDR_LOW, 32'h23);
    rdc(`PFS_OFS_CTRL, k_mod | k_er | k_rg | k_ft);
    apb(1'b1, `PFS_OFS_KEY, 32'haa);
    apb(1'b1, `PFS_OFS_CTRL, k_go | k_mod | k_er);
    repeat (3) @(posedge core_clk);
    chk(n_erase, n);
    // Latch loads then row program, twice
    apb(1'b1, `PFS_OFS_CTRL, k_mod | k_lt);
    p = n_prog;
    ld(8'h40, 14'h1234);
    ld(8'h45, 14'h0abc);
    ld(8'h5f, 14'h2001);
    chk(n_prog, p);
    rdc(`PFS_OFS_CTRL, k_mod | k_lt);
    apb(1'b1, `PFS_OFS_CTRL, k_mod);
    apb(1'b1, `PFS_OFS_ADDR_LOW, 32'h4a);
    for (int t = 0; t < 2; t++) begin
      n = n_erase;
      p = n_prog;
      unlock(k_go | k_mod);
      wait_idle();
      chk(n_prog, p + 32);
      chk(n_erase, n);
      chk(32'(p_row), 32'h00a);
      for (int i = 0; i < 32; i++)
        chk(32'(pm[i]), t ? 32'h3fff : i == 0 ? 32'h1234 : i == 5 ? 32'h0abc :
          i == 31 ? 32'h2001 : 32'h3fff);
      rdc(`PFS_OFS_CTRL, k_mod | k_dn);
      apb(1'b1, `PFS_OFS_CTRL, k_mod);
    end
    // Flash reports a write torn by reset
    flash_torn <= 1'b1;
    repeat (4) @(posedge core_clk);
    flash_torn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdc(`PFS_OFS_CTRL, k_mod | k_ft);
    // Reset in mid-erase drops the stall and clears the registers
    unlock(k_go | k_mod | k_er);
    repeat (5) @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    chk(32'(cpu_stall), 0);
    reset <= 1'b0;
    rdc(`PFS_OFS_CTRL, 32'h0);
    complete_run();
  end
endmodule

bind pfs_row_sequencer pfs_row_sequencer_props #(.ERASE_CYCLES(ERASE_CYCLES)) u_props (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
  .cpu_stall(cpu_stall));
`default_nettype wire
